// file: php_host_model.sv
`timescale 1ns/100ps
module php_host_model (
    // Clock
    input  wire logic                       mclk,
    // Processor bus
    output logic      [1:0]                 port_select,
    output logic                            host_rd_n,
    output logic                            host_wr_n,
    output logic      [php_pkg::BYTE_W-1:0] host_data_in,
    input  wire logic [php_pkg::BYTE_W-1:0] host_data_out
);
    import php_pkg::*;
    // Margins above the port's strobe and gap minimums
    localparam int LOW_CYC = 6;
    localparam int GAP_CYC = 8;
    initial begin
        port_select  = SEL_WPTR;
        host_rd_n    = 1'b1;
        host_wr_n    = 1'b1;
        host_data_in = 8'h00;
    end
    task automatic access(input logic rd, input logic [1:0] sel, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge mclk);
        port_select  <= sel;
        host_data_in <= rd ? ~host_data_in : d;
        host_rd_n    <= !rd;
        host_wr_n    <= rd;
        repeat (LOW_CYC) @(posedge mclk);
        q = host_data_out;
        host_rd_n <= 1'b1;
        host_wr_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // Released byte must not linger as a stale match
        host_data_in <= ~host_data_in;
        repeat (GAP_CYC) @(posedge mclk);
    endtask
endmodule // php_host_model

// file: php_palette_port.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module php_palette_port (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // AXI4-Lite slave
    input  wire logic [php_pkg::AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [php_pkg::AXI_DW-1:0]  s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic      [1:0]                  s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [php_pkg::AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic      [php_pkg::AXI_DW-1:0]  s_axi_rdata,
    output logic      [1:0]                  s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Host processor port
    input  wire logic [1:0]                  port_select,
    input  wire logic                        host_rd_n,
    input  wire logic                        host_wr_n,
    input  wire logic [php_pkg::BYTE_W-1:0]  host_data_in,
    output logic      [php_pkg::BYTE_W-1:0]  host_data_out,
    output logic                             host_data_oe_n,
    // Display path
    input  wire logic [php_pkg::PAL_AW-1:0]  pixel_index,
    output logic      [php_pkg::PAL_DW-1:0]  pixel_color
);
    import php_pkg::*;

    function automatic logic [7:0] width_mask(input logic [7:0] b, input logic six);
        width_mask = b & (six ? SIX_MASK : EIGHT_MASK);
    endfunction

    // Control register and state
    logic                indexed_access_enable;
    logic                six_bit_mode;
    logic [PAL_AW-1:0]   write_addr_pointer;
    logic [PAL_AW-1:0]   read_addr_pointer;
    logic [7:0]          pixel_read_mask;
    logic [1:0]          comp;
    logic                dir_read;
    logic [7:0]          red_buf;
    logic [7:0]          green_buf;
    logic [PAL_DW-1:0]   hold;
    logic                fetch_pending;
    php_xfer_t           xf_state;
    php_xfer_t           next_xf_state;
    logic [7:0]          ext_reg [0:(1<<PAL_AW)-1];

    // Strobe synchronisers, bit 0 read, bit 1 write
    logic [1:0]          strb_raw;
    logic [1:0]          strb_s1;
    logic [1:0]          strb_s2;
    logic [1:0]          strb_s3;

    assign strb_raw = {host_wr_n, host_rd_n};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    strb_s1[gi] <= 1'b1;
                    strb_s2[gi] <= 1'b1;
                    strb_s3[gi] <= 1'b1;
                end else begin
                    strb_s1[gi] <= strb_raw[gi];
                    strb_s2[gi] <= strb_s1[gi];
                    strb_s3[gi] <= strb_s2[gi];
                end
            end
        end
    endgenerate

    // Access decode
    logic       rd_active;
    logic       wr_active;
    logic       rd_start;
    logic       rd_end;
    logic       wr_end;
    logic       host_gap;
    logic [1:0] acc_sel;
    logic [7:0] wr_data;

    assign rd_active = !strb_s2[0];
    assign wr_active = !strb_s2[1];
    assign rd_start  = strb_s3[0] && !strb_s2[0];
    assign rd_end    = !strb_s3[0] && strb_s2[0];
    assign wr_end    = !strb_s3[1] && strb_s2[1];
    // Transfers only start while both strobes rest high
    assign host_gap  = strb_s2[0] && strb_s2[1] && strb_s3[0] && strb_s3[1];

    // Select and data are held for the whole strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc_sel <= SEL_WPTR;
            wr_data <= 8'h00;
        end else begin
            if (rd_active || wr_active) begin
                acc_sel <= port_select;
            end
            if (wr_active) begin
                wr_data <= host_data_in;
            end
        end
    end

    logic w_wptr;
    logic w_rptr;
    logic w_data;
    logic w_mask;
    logic r_data;
    logic idx_sel;
    logic blue_now;
    logic pal_store;
    logic blue_read;

    assign w_wptr    = wr_end && (acc_sel == SEL_WPTR);
    assign w_rptr    = wr_end && (acc_sel == SEL_RPTR);
    assign w_data    = wr_end && (acc_sel == SEL_DATA);
    assign w_mask    = wr_end && (acc_sel == SEL_MASK);
    assign r_data    = rd_end && (acc_sel == SEL_DATA);
    assign idx_sel   = indexed_access_enable;
    assign blue_now  = (comp == COMP_BLUE);
    assign pal_store = w_data && !dir_read && blue_now;
    assign blue_read = r_data && dir_read && blue_now;

    // Component counter, cleared by pointer writes only
    logic [1:0] next_comp;
    assign next_comp = (w_wptr || w_rptr) ? COMP_RED :
                       (w_data || r_data) ? (blue_now ? COMP_RED : comp + 2'h1) :
                       comp;

    // Pointers; 8-bit add wraps 0xff to 0x00
    logic [PAL_AW-1:0] next_wptr;
    logic [PAL_AW-1:0] next_rptr;
    assign next_wptr = w_wptr    ? wr_data :
                       pal_store ? write_addr_pointer + 8'h01 :
                       write_addr_pointer;
    assign next_rptr = w_rptr                    ? wr_data :
                       (xf_state == PHP_XF_LOAD) ? read_addr_pointer + 8'h01 :
                       read_addr_pointer;

    // New fetch request wins over completion of the old one
    logic next_fetch_pending;
    assign next_fetch_pending = w_rptr || blue_read ||
                                (fetch_pending && (xf_state != PHP_XF_LOAD));

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            write_addr_pointer <= PTR_RST;
            read_addr_pointer  <= PTR_RST;
            comp               <= COMP_RED;
            fetch_pending      <= 1'b0;
        end else begin
            write_addr_pointer <= next_wptr;
            read_addr_pointer  <= next_rptr;
            comp               <= next_comp;
            fetch_pending      <= next_fetch_pending;
        end
    end

    // Direction follows the last pointer written; reads leave it alone
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir_read <= 1'b0;
        end else if (w_rptr) begin
            dir_read <= 1'b1;
        end else if (w_wptr) begin
            dir_read <= 1'b0;
        end
    end

    // Red and green wait here for the blue byte
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            red_buf   <= 8'h00;
            green_buf <= 8'h00;
        end else if (w_data && !dir_read) begin
            if (comp == COMP_RED) begin
                red_buf <= width_mask(wr_data, six_bit_mode);
            end
            if (comp == COMP_GREEN) begin
                green_buf <= width_mask(wr_data, six_bit_mode);
            end
        end
    end

    // Read mask or indexed extended register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pixel_read_mask <= MASK_RST;
        end else if (w_mask && !idx_sel) begin
            pixel_read_mask <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (w_mask && idx_sel) begin
            ext_reg[write_addr_pointer] <= wr_data;
        end
    end

    // Transfer sequencer
    always_comb begin
        next_xf_state = xf_state;
        unique case (xf_state)
            PHP_XF_IDLE: begin
                if (fetch_pending && host_gap) begin
                    next_xf_state = PHP_XF_READ;
                end
            end
            PHP_XF_READ: begin
                next_xf_state = PHP_XF_LOAD;
            end
            PHP_XF_LOAD: begin
                next_xf_state = PHP_XF_IDLE;
            end
            default: begin
                next_xf_state = PHP_XF_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            xf_state <= PHP_XF_IDLE;
        end else begin
            xf_state <= next_xf_state;
        end
    end

    // Palette RAM shared by display and transfers
    logic [PAL_DW-1:0] ram_q;
    logic [PAL_DW-1:0] ram_wdata;
    logic [PAL_AW-1:0] ram_raddr;
    logic              xfer_busy;
    logic              disp_rd;
    logic              disp_rd_d;

    assign ram_wdata = {red_buf, green_buf, width_mask(wr_data, six_bit_mode)};
    assign xfer_busy = (xf_state != PHP_XF_IDLE) || pal_store;
    assign disp_rd   = !xfer_busy;
    assign ram_raddr = (xf_state == PHP_XF_READ) ? read_addr_pointer :
                       (pixel_index & pixel_read_mask);

    php_palette_ram u_ram (
        .mclk  (mclk),
        .we    (pal_store),
        .waddr (write_addr_pointer),
        .wdata (ram_wdata),
        .re    (disp_rd || (xf_state == PHP_XF_READ)),
        .raddr (ram_raddr),
        .q     (ram_q)
    );

    // Holding register loads one cycle after the RAM read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hold <= '0;
        end else if (xf_state == PHP_XF_LOAD) begin
            hold <= ram_q;
        end
    end

    // Display keeps its last colour through transfer cycles
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            disp_rd_d   <= 1'b0;
            pixel_color <= '0;
        end else begin
            disp_rd_d <= disp_rd;
            if (disp_rd_d) begin
                pixel_color <= ram_q;
            end
        end
    end

    // Host read data, captured at the start of the read strobe
    logic [7:0] hold_byte;
    logic [7:0] rd_value;
    assign hold_byte = (comp == COMP_RED)   ? hold[23:16] :
                       (comp == COMP_GREEN) ? hold[15:8]  :
                       hold[7:0];
    assign rd_value  = (port_select == SEL_WPTR) ? write_addr_pointer :
                       (port_select == SEL_RPTR) ? read_addr_pointer  :
                       (port_select == SEL_DATA) ? width_mask(hold_byte, six_bit_mode) :
                       idx_sel ? ext_reg[write_addr_pointer] : pixel_read_mask;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            host_data_out <= 8'h00;
        end else if (rd_start) begin
            host_data_out <= rd_value;
        end
    end

    // Drives only while the synchronised read strobe is low
    assign host_data_oe_n = !(rd_active && !rd_start);

    // AXI4-Lite write channel
    logic              aw_got;
    logic              w_got;
    logic [AXI_AW-1:0] aw_q;
    logic [AXI_DW-1:0] wd_q;
    logic [3:0]        ws_q;
    logic              aw_fire;
    logic              w_fire;
    logic              do_write;
    logic [AXI_AW-1:0] wa_eff;
    logic [AXI_DW-1:0] wd_eff;
    logic [3:0]        ws_eff;
    logic              wa_ok;

    assign s_axi_awready = !aw_got && !s_axi_bvalid;
    assign s_axi_wready  = !w_got && !s_axi_bvalid;
    assign aw_fire  = s_axi_awvalid && s_axi_awready;
    assign w_fire   = s_axi_wvalid && s_axi_wready;
    assign do_write = (aw_got || aw_fire) && (w_got || w_fire);
    assign wa_eff   = aw_got ? aw_q : s_axi_awaddr;
    assign wd_eff   = w_got ? wd_q : s_axi_wdata;
    assign ws_eff   = w_got ? ws_q : s_axi_wstrb;
    assign wa_ok    = (wa_eff == OFS_CTRL) || (wa_eff == OFS_STATUS);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            aw_q         <= '0;
            wd_q         <= '0;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
        end else begin
            if (aw_fire) begin
                aw_got <= 1'b1;
                aw_q   <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_got <= 1'b1;
                wd_q  <= s_axi_wdata;
                ws_q  <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control bits steer indexing and colour width
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            indexed_access_enable <= 1'b0;
            six_bit_mode          <= 1'b0;
        end else if (do_write && (wa_eff == OFS_CTRL) && ws_eff[0]) begin
            indexed_access_enable <= wd_eff[CTRL_IDX_EN];
            six_bit_mode          <= wd_eff[CTRL_SIX_BIT];
        end
    end

    // AXI4-Lite read channel; counter stays hidden
    logic [AXI_DW-1:0] ctrl_word;
    logic [AXI_DW-1:0] stat_word;
    logic              ar_fire;

    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;
    assign ctrl_word = {30'h0, six_bit_mode, indexed_access_enable};
    assign stat_word = {14'h0, xfer_busy, dir_read, read_addr_pointer, write_addr_pointer};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= (s_axi_araddr == OFS_CTRL)   ? ctrl_word :
                            (s_axi_araddr == OFS_STATUS) ? stat_word : '0;
            s_axi_rresp  <= ((s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_STATUS)) ?
                            RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // php_palette_port

// file: php_palette_port_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module php_palette_port_bench;
    import php_pkg::*;
    logic        mclk, rstn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, rd_n, wr_n, oe_n;
    logic [7:0]  awa, ara, din, dout, pidx, q;
    logic [31:0] wd, rdat, v, seed;
    logic [3:0]  ws;
    logic [1:0]  bre, rre, sel, r;
    logic [23:0] pcol;
    logic [23:0] pal [3];
    int          bad_count, tests_run;
    php_palette_port dut_u (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .port_select(sel),
        .host_rd_n(rd_n), .host_wr_n(wr_n), .host_data_in(din), .host_data_out(dout),
        .host_data_oe_n(oe_n), .pixel_index(pidx), .pixel_color(pcol));
    php_host_model host_u (.mclk(mclk), .port_select(sel), .host_rd_n(rd_n),
        .host_wr_n(wr_n), .host_data_in(din), .host_data_out(dout));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge mclk);
        {awa, wd, ws} <= {a, d, 4'hf};
        {awv, wv, br} <= 3'b111;
        while (!(a_ok && w_ok)) begin
            @(posedge mclk);
            if (!a_ok && awr === 1'b1) begin
                a_ok = 1'b1;
                awv <= 1'b0;
            end
            if (!w_ok && wr === 1'b1) begin
                w_ok = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge mclk); while (bv !== 1'b1);
        r = bre;
        br <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge mclk);
        {ara, arv, rr} <= {a, 2'b11};
        do @(posedge mclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge mclk); while (rv !== 1'b1);
        {r, v} = {rre, rdat};
        rr <= 1'b0;
    endtask
    task automatic stat(input logic [7:0] wp, input logic [7:0] rp, input logic dir);
        axr(OFS_STATUS);
        `CHK({r, v[17:0]}, {RESP_OKAY, 1'b0, dir, rp, wp})
    endtask
    task automatic hw(input logic [1:0] s, input logic [7:0] d);
        host_u.access(1'b0, s, d, q);
    endtask
    task automatic hr(input logic [1:0] s);
        host_u.access(1'b1, s, 8'h00, q);
    endtask
    task automatic results();
        $display("mismatches %0d of %0d comparisons", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {rstn, awv, wv, br, arv, rr, awa, ara, wd, ws, pidx} = '0;
        {bad_count, tests_run} = '0;
        seed = 32'hf8b4;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        axr(OFS_CTRL);
        `CHK({r, v}, {RESP_OKAY, 32'h0})
        stat(8'h00, 8'h00, 1'b0);
        axr(8'h08);
        `CHK({r, v}, {RESP_SLVERR, 32'h0})
        axw(8'h0c, 32'h1);
        `CHK(r, RESP_SLVERR)
        // Stray red byte must be dropped by the reload
        hw(SEL_WPTR, 8'h10);
        hw(SEL_DATA, 8'haa);
        hw(SEL_WPTR, 8'hfe);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            pal[k] = seed[23:0] ^ 24'h5a3c96;
            for (int c = 0; c < 3; c++) hw(SEL_DATA, pal[k][23-8*c -: 8]);
        end
        stat(8'h01, 8'h00, 1'b0);
        hr(SEL_WPTR);
        `CHK(q, 8'h01)
        stat(8'h01, 8'h00, 1'b0);
        hw(SEL_RPTR, 8'hfe);
        stat(8'h01, 8'hff, 1'b1);
        for (int k = 0; k < 3; k++)
            for (int c = 0; c < 3; c++) begin
                hr(SEL_DATA);
                `CHK(q, pal[k][23-8*c -: 8])
            end
        stat(8'h01, 8'h02, 1'b1);
        hr(SEL_RPTR);
        `CHK(q, 8'h02)
        pidx <= 8'hff;
        repeat (40) @(posedge mclk);
        `CHK(pcol, pal[1])
        hw(SEL_MASK, 8'h00);
        `CHK(pcol, pal[2])
        hr(SEL_MASK);
        `CHK(q, 8'h00)
        axw(OFS_CTRL, 32'h1);
        `CHK(r, RESP_OKAY)
        axr(OFS_CTRL);
        `CHK({r, v}, {RESP_OKAY, 32'h1})
        hw(SEL_WPTR, 8'h05);
        hw(SEL_MASK, seed[7:0]);
        hr(SEL_MASK);
        `CHK(q, seed[7:0])
        `CHK(pcol, pal[2])
        // Random round trips anywhere in the palette, odd passes in six-bit mode
        for (int n = 0; n < 4; n++) begin
            axw(OFS_CTRL, {30'h0, n[0], 1'b0});
            seed = lfsr(lfsr(seed));
            hw(SEL_WPTR, seed[31:24] ^ seed[7:0]);
            for (int c = 0; c < 3; c++) hw(SEL_DATA, seed[23-8*c -: 8]);
            hw(SEL_RPTR, seed[31:24] ^ seed[7:0]);
            for (int c = 0; c < 3; c++) begin
                hr(SEL_DATA);
                `CHK(q, seed[23-8*c -: 8] & (n[0] ? SIX_MASK : EIGHT_MASK))
                if (c == 0) begin
                    // Pointer read mid-triplet keeps the colour counter
                    hr(SEL_WPTR);
                    `CHK(q, (seed[31:24] ^ seed[7:0]) + 8'h01)
                end
            end
        end
        results();
    end
    initial begin
        #40000;
        bad_count++;
        results();
    end
endmodule // php_palette_port_bench

// file: php_palette_port_sva.sv
`timescale 1ns/100ps
module php_palette_port_sva (
    // Clock and reset
    input wire logic                       mclk,
    input wire logic                       rstn,
    // Register bus
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wready,
    input wire logic                       s_axi_bvalid,
    input wire logic [1:0]                 s_axi_bresp,
    input wire logic                       s_axi_bready,
    input wire logic [php_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [php_pkg::AXI_DW-1:0] s_axi_rdata,
    input wire logic [1:0]                 s_axi_rresp,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    // Host and display
    input wire logic                       host_rd_n,
    input wire logic                       host_wr_n,
    input wire logic [php_pkg::BYTE_W-1:0] host_data_out,
    input wire logic                       host_data_oe_n,
    input wire logic [php_pkg::PAL_AW-1:0] pixel_index,
    input wire logic [php_pkg::PAL_DW-1:0] pixel_color
);
    import php_pkg::*;
    logic [4:0] quiet_cnt;
    logic [2:0] idx_cnt;
    wire        quiet_now = host_rd_n && host_wr_n;
    // Saturating counts: host idle time and steady pixel index
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            quiet_cnt <= 5'h00;
            idx_cnt   <= 3'h0;
        end else begin
            quiet_cnt <= !quiet_now ? 5'h00 : quiet_cnt + {4'h0, quiet_cnt != 5'h1f};
            idx_cnt   <= !$stable(pixel_index) ? 3'h0 : idx_cnt + {2'h0, idx_cnt != 3'h7};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("bresp dropped early");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata});
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped early");
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("write taken during response");
    property p_ar_err;
        s_axi_arvalid && s_axi_arready && s_axi_araddr != OFS_CTRL && s_axi_araddr != OFS_STATUS
            |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
    endproperty
    a_ar_err: assert property (p_ar_err) else $error("unmapped read not refused");
    // Host drive only follows a read strobe
    property p_oe_window;
        !host_data_oe_n |-> !$past(host_rd_n) || !$past(host_rd_n, 2)
            || !$past(host_rd_n, 3) || !$past(host_rd_n, 4);
    endproperty
    a_oe_window: assert property (p_oe_window) else $error("data driven without read");
    property p_oe_quiet;
        host_rd_n [*4] |=> host_data_oe_n;
    endproperty
    a_oe_quiet: assert property (p_oe_quiet) else $error("data still driven when idle");
    property p_dout_cause;
        $changed(host_data_out) |-> !$past(host_rd_n) || !$past(host_rd_n, 2)
            || !$past(host_rd_n, 3) || !$past(host_rd_n, 4);
    endproperty
    a_dout_cause: assert property (p_dout_cause) else $error("read data moved unasked");
    property p_pix_quiet;
        quiet_cnt == 5'h1f && idx_cnt == 3'h7 |-> $stable(pixel_color);
    endproperty
    a_pix_quiet: assert property (p_pix_quiet) else $error("colour moved while idle");
    c_err_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_host_read: cover property ($fell(host_data_oe_n));
    c_pix_quiet: cover property (quiet_cnt == 5'h1f && idx_cnt == 3'h7);
endmodule // php_palette_port_sva

bind php_palette_port php_palette_port_sva chk_u (.mclk, .rstn, .s_axi_awready, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_rd_n, .host_wr_n,
    .host_data_out, .host_data_oe_n, .pixel_index, .pixel_color);

// file: php_palette_ram.sv
`timescale 1ns/100ps
module php_palette_ram (
    // Clock
    input  wire logic                        mclk,
    // Write port
    input  wire logic                        we,
    input  wire logic [php_pkg::PAL_AW-1:0]  waddr,
    input  wire logic [php_pkg::PAL_DW-1:0]  wdata,
    // Read port
    input  wire logic                        re,
    input  wire logic [php_pkg::PAL_AW-1:0]  raddr,
    output logic      [php_pkg::PAL_DW-1:0]  q
);
    import php_pkg::*;

    logic [PAL_DW-1:0] mem [0:(1<<PAL_AW)-1];

    // Contents need no reset; software loads them
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (re) begin
            q <= mem[raddr];
        end
    end
endmodule // php_palette_ram

// file: php_pkg.sv
package php_pkg;
    // Host port select codes
    localparam logic [1:0] SEL_WPTR = 2'h0;
    localparam logic [1:0] SEL_DATA = 2'h1;
    localparam logic [1:0] SEL_MASK = 2'h2;
    localparam logic [1:0] SEL_RPTR = 2'h3;

    // Colour component counter codes
    localparam logic [1:0] COMP_RED   = 2'h0;
    localparam logic [1:0] COMP_GREEN = 2'h1;
    localparam logic [1:0] COMP_BLUE  = 2'h2;

    // Widths
    localparam int PAL_AW = 8;
    localparam int BYTE_W = 8;
    localparam int PAL_DW = 24;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;

    // Reset values and colour width masks
    localparam logic [7:0] PTR_RST  = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] SIX_MASK = 8'h3f;
    localparam logic [7:0] EIGHT_MASK = 8'hff;

    // AXI4-Lite register map
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam int CTRL_IDX_EN  = 0;
    localparam int CTRL_SIX_BIT = 1;
    localparam int STAT_WPTR_LSB = 0;
    localparam int STAT_RPTR_LSB = 8;
    localparam int STAT_DIR_RD   = 16;
    localparam int STAT_BUSY     = 17;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Palette-to-holding transfer states, Gray ordered
    typedef enum logic [1:0] {
        PHP_XF_IDLE = 2'h0,
        PHP_XF_READ = 2'h1,
        PHP_XF_LOAD = 2'h3
    } php_xfer_t;
endpackage
